// ### event_log_regs.vh
// Purpose: Register offsets, reset values and sizes for the event log
//          access port.
// Assumes: Byte-wide register map with one-byte register addresses.
// Notes:   Definitions only; included by bare name.
`ifndef EVENT_LOG_REGS_VH
`define EVENT_LOG_REGS_VH

// Register map offsets
`define OFS_CTRL_LAST      8'h0f
`define OFS_NV_FIRST       8'h10
`define OFS_NV_LAST        8'h2f
`define OFS_EXT_RD_LAST    8'h3c
`define OFS_INTERVAL_LOW   8'h3d
`define OFS_INTERVAL_HIGH  8'h3e
`define OFS_NEXT_PTR_LOW   8'h3f
`define OFS_NEXT_PTR_HIGH  8'h40
`define OFS_LOG_ADDR_LOW   8'h41
`define OFS_LOG_ADDR_HIGH  8'h42
`define OFS_LOG_DATA       8'h43
`define OFS_RESERVED_FIRST 8'h44

// Log memory geometry
`define LOG_ADDR_W         11
`define LOG_ADDR_LAST      11'h7ff
`define LOG_BYTES          2048

// Reset and fixed read values, read FIFO depth
`define RESERVED_READ      8'h00
`define REG_PTR_RESET      8'h00
`define LOG_ADDR_RESET     11'h000
`define NEXT_PTR_RESET     11'h000
`define READ_FIFO_DEPTH    4

`endif

// ### log_ram.v
// Purpose: Event log byte memory, one write port and one read port.
// Assumes: Read data is registered, valid one cycle after rd_en_in.
// Notes:   Writer and reader never collide on purpose; reads above the
//          user area are masked while a mission runs.
`timescale 1ns/1ps
module log_ram #(
  parameter ADDR_W = 11,
  parameter DATA_W = 8
) (
  // Clock
  input  wire              clock_in,
  // Write port
  input  wire              wr_en_in,
  input  wire [ADDR_W-1:0] wr_addr_in,
  input  wire [DATA_W-1:0] wr_data_in,
  // Read port
  input  wire              rd_en_in,
  input  wire [ADDR_W-1:0] rd_addr_in,
  output reg  [DATA_W-1:0] rd_data_out
);
  reg [DATA_W-1:0] mem_reg [0:(1<<ADDR_W)-1];

  // No reset on the array, which maps to block memory
  always @(posedge clock_in) begin
    if (wr_en_in) begin
      mem_reg[wr_addr_in] <= wr_data_in;
    end
    if (rd_en_in) begin
      rd_data_out <= mem_reg[rd_addr_in];
    end
  end
endmodule // log_ram

// ### byte_fifo.v
// Purpose: Small valid/ready FIFO for read answers.
// Assumes: DEPTH is a power of two.
// Notes:   Full and empty from pointers with one extra wrap bit.
`timescale 1ns/1ps
module byte_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4,
  parameter PTR_W = 2
) (
  // Clock and reset
  input  wire             clock_in,
  input  wire             rst_b_in,
  // Fill side
  input  wire             in_valid_in,
  output wire             in_ready_out,
  input  wire [WIDTH-1:0] in_data_in,
  // Drain side
  output wire             out_valid_out,
  input  wire             out_ready_in,
  output wire [WIDTH-1:0] out_data_out
);
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [PTR_W:0]   wr_ptr_reg;
  reg [PTR_W:0]   rd_ptr_reg;
  wire            full;
  wire            empty;
  integer         i;

  // Full when pointers differ only in the wrap bit
  assign full  = (wr_ptr_reg[PTR_W] != rd_ptr_reg[PTR_W]) &&
                 (wr_ptr_reg[PTR_W-1:0] == rd_ptr_reg[PTR_W-1:0]);
  assign empty = (wr_ptr_reg == rd_ptr_reg);
  assign in_ready_out  = ~full;
  assign out_valid_out = ~empty;
  assign out_data_out  = mem_reg[rd_ptr_reg[PTR_W-1:0]];

  // Pointer and storage update
  always @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wr_ptr_reg <= {(PTR_W+1){1'b0}};
      rd_ptr_reg <= {(PTR_W+1){1'b0}};
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem_reg[i] <= {WIDTH{1'b0}};
      end
    end else begin
      if (in_valid_in && !full) begin
        mem_reg[wr_ptr_reg[PTR_W-1:0]] <= in_data_in;
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (out_ready_in && !empty) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end
endmodule // byte_fifo

// ### event_log_access_port.v
// Purpose: Byte register map behind the serial host interface, with the
//          indirect port into the event log memory.
// Assumes: A serial front end delivers start, stop, written bytes and
//          read requests as one-cycle strobes synchronous to clock_in.
// Notes:   Clock, control and user storage live outside; this block
//          forwards their accesses on the ext_* strobes.
// Function
// RULE1 - Power fail blocks every register read and write until it clears.
// RULE2 - Indirect port: address low 41h, address high 42h, data 43h.
// RULE3 - Pointer moves 41h to 42h to 43h after each address write.
// RULE4 - Data read bumps log address; register pointer stays at 43h.
// RULE5 - Log address stops at 07FFh; host must rewrite it.
// RULE6 - Only the low 11 address bits are kept.
// RULE7 - Event interval stored low byte even, high byte odd, from 0000.
// RULE8 - Next-write log pointer kept, readable at 3Fh and 40h.
// RULE9 - After wrap the next-write pointer names the oldest entry.
// RULE10 - 3Dh and 3Eh read the live interval counter. Here 3Eh returns the high byte held from the last 3Dh read.
// RULE11 - 00h-0Fh clock and control, 10h-2Fh user storage decoded.
// RULE12 - From 44h upward reads return 00h.
// RULE13 - Writes act only in 00h-2Fh; rest is read-only. Here writes to 41h and 42h also set the log address.
// RULE14 - Mission makes map read-only; a write ends the mission.
// RULE15 - Event being stored finishes before the mission stop is issued.
// RULE16 - During a mission reads above 2Fh return 00h.
// RULE17 - Host writes address low, high, restarts for read, reads on.
// RULE18 - The 2048-byte log is reachable only through the port.
// RULE19 - Register pointer advances after each byte until stop.
// RULE20 - Power fail and mission status inputs gate host access.
`timescale 1ns/1ps
`include "event_log_regs.vh"
module event_log_access_port #(
  parameter FIFO_DEPTH = `READ_FIFO_DEPTH,
  parameter FIFO_PTR_W = 2
) (
  // Clock and reset
  input  wire        clock_in,
  input  wire        rst_b_in,
  // Byte transfer port from the serial front end
  input  wire        host_start_in,
  input  wire        host_stop_in,
  input  wire        host_wr_valid_in,
  input  wire [7:0]  host_wr_data_in,
  input  wire        host_rd_req_in,
  output wire        host_rd_ready_out,
  output wire        host_rd_valid_out,
  output wire [7:0]  host_rd_data_out,
  input  wire        host_rd_ack_in,
  // Recorder status
  input  wire        power_fail_threshold_in,
  input  wire        mission_active_flag_in,
  input  wire        mission_enable_bit_in,
  input  wire        event_store_busy_in,
  input  wire [15:0] elapsed_interval_counter_in,
  // Logging engine write into the log
  input  wire        log_wr_en_in,
  input  wire [10:0] log_wr_addr_in,
  input  wire [7:0]  log_wr_data_in,
  // Clock, control and user storage outside this block
  output wire        ext_wr_out,
  output wire        ext_rd_out,
  output wire [5:0]  ext_addr_out,
  output wire [7:0]  ext_wdata_out,
  input  wire [7:0]  ext_rdata_in,
  // Mission control and status
  output wire        mission_stop_out,
  output wire        access_blocked_out,
  output wire [10:0] next_write_ptr_out
);
  // Read pipeline states, one-hot
  localparam [1:0] ST_IDLE  = 2'b01;
  localparam [1:0] ST_FETCH = 2'b10;

  // Answer source select
  localparam [1:0] SRC_LOCAL = 2'b00;
  localparam [1:0] SRC_EXT   = 2'b01;
  localparam [1:0] SRC_RAM   = 2'b10;

  reg  [1:0]  state_reg;
  reg  [1:0]  state_next;
  reg  [1:0]  src_reg;
  reg  [1:0]  src_next;
  reg  [7:0]  local_byte_reg;
  reg  [7:0]  local_byte_next;
  reg  [7:0]  reg_ptr_reg;
  reg  [7:0]  reg_ptr_next;
  reg         addr_phase_reg;
  reg         addr_phase_next;
  reg  [10:0] log_addr_reg;
  reg  [10:0] log_addr_next;
  reg  [10:0] next_ptr_reg;
  reg  [7:0]  interval_high_reg;
  reg  [7:0]  interval_high_next;
  reg         stop_pend_reg;
  reg         stop_pulse_reg;
  reg         ext_wr_reg;
  reg         ext_wr_next;
  reg         ext_rd_reg;
  reg         ext_rd_next;
  reg  [5:0]  ext_addr_reg;
  reg  [5:0]  ext_addr_next;
  reg  [7:0]  ext_wdata_reg;
  reg  [7:0]  ext_wdata_next;
  reg         ram_rd_en;
  reg         mission_write;

  wire        blocked;
  wire        mission_on;
  wire        rd_take;
  wire        wr_take;
  wire        fifo_in_ready;
  wire        fifo_push;
  wire [7:0]  ram_rd_data;
  wire [7:0]  push_data;

  // RULE20 status gating
  assign blocked    = power_fail_threshold_in;
  assign mission_on = mission_active_flag_in | mission_enable_bit_in;

  // Read requests only while idle and the answer queue has room
  assign host_rd_ready_out = (state_reg == ST_IDLE) & fifo_in_ready;
  assign rd_take = host_rd_req_in & host_rd_ready_out;
  assign wr_take = host_wr_valid_in;

  assign ext_wr_out         = ext_wr_reg;
  assign ext_rd_out         = ext_rd_reg;
  assign ext_addr_out       = ext_addr_reg;
  assign ext_wdata_out      = ext_wdata_reg;
  assign mission_stop_out   = stop_pulse_reg;
  assign access_blocked_out = blocked;
  assign next_write_ptr_out = next_ptr_reg;

  // Answer byte chosen in the fetch cycle
  assign push_data = (src_reg == SRC_RAM) ? ram_rd_data :
                     (src_reg == SRC_EXT) ? ext_rdata_in : local_byte_reg;
  assign fifo_push = (state_reg == ST_FETCH);

  // Host side: pointer, indirect address, writes and read decode
  always @* begin
    state_next         = state_reg;
    src_next           = src_reg;
    local_byte_next    = local_byte_reg;
    reg_ptr_next       = reg_ptr_reg;
    addr_phase_next    = addr_phase_reg;
    log_addr_next      = log_addr_reg;
    interval_high_next = interval_high_reg;
    ext_wr_next        = 1'b0;
    ext_rd_next        = 1'b0;
    ext_addr_next      = ext_addr_reg;
    ext_wdata_next     = ext_wdata_reg;
    ram_rd_en          = 1'b0;
    mission_write      = 1'b0;
    if (blocked) begin
      // RULE1 refuse access; pointer resets, writes are dropped and reads answer 00h
      reg_ptr_next    = `REG_PTR_RESET;
      addr_phase_next = 1'b0;
      if (rd_take) begin
        src_next        = SRC_LOCAL;
        local_byte_next = `RESERVED_READ;
        state_next      = ST_FETCH;
      end
    end else if (host_start_in) begin
      // First written byte after a start names the register
      addr_phase_next = 1'b1;
    end else if (host_stop_in) begin
      addr_phase_next = 1'b0;
    end else if (wr_take && addr_phase_reg) begin
      reg_ptr_next    = host_wr_data_in;
      addr_phase_next = 1'b0;
    end else if (wr_take) begin
      // RULE19 pointer steps after each written byte
      reg_ptr_next = reg_ptr_reg + 8'h01;
      if (mission_on) begin
        // RULE14 map read-only, write ends the mission
        mission_write = 1'b1;
      end else if (reg_ptr_reg <= `OFS_NV_LAST) begin
        // RULE13 writes reach only clock, control and user storage
        // RULE11 lower map decoded for the outside registers
        ext_wr_next    = 1'b1;
        ext_addr_next  = reg_ptr_reg[5:0];
        ext_wdata_next = host_wr_data_in;
      end else if (reg_ptr_reg == `OFS_LOG_ADDR_LOW) begin
        // RULE2 indirect address low byte
        // RULE3 next byte lands on the high address byte
        log_addr_next = {log_addr_reg[10:8], host_wr_data_in};
      end else if (reg_ptr_reg == `OFS_LOG_ADDR_HIGH) begin
        // RULE6 upper five bits dropped
        log_addr_next = {host_wr_data_in[2:0], log_addr_reg[7:0]};
      end
    end else if (rd_take) begin
      state_next      = ST_FETCH;
      src_next        = SRC_LOCAL;
      local_byte_next = `RESERVED_READ;
      // RULE19 pointer steps after each read byte except at 43h
      reg_ptr_next    = reg_ptr_reg + 8'h01;
      if (mission_on && (reg_ptr_reg > `OFS_NV_LAST)) begin
        // RULE16 upper map hidden during a mission
        local_byte_next = `RESERVED_READ;
        if (reg_ptr_reg == `OFS_LOG_DATA) begin
          reg_ptr_next = reg_ptr_reg;
        end
      end else if (reg_ptr_reg <= `OFS_EXT_RD_LAST) begin
        // RULE11 lower map read from the outside registers
        src_next      = SRC_EXT;
        ext_rd_next   = 1'b1;
        ext_addr_next = reg_ptr_reg[5:0];
      end else begin
        case (reg_ptr_reg)
          `OFS_INTERVAL_LOW: begin
            // RULE10 live counter; high byte held for a clean pair
            local_byte_next    = elapsed_interval_counter_in[7:0];
            interval_high_next = elapsed_interval_counter_in[15:8];
          end
          `OFS_INTERVAL_HIGH: begin
            local_byte_next = interval_high_reg;
          end
          `OFS_NEXT_PTR_LOW: begin
            // RULE8 stored next-write pointer
            local_byte_next = next_ptr_reg[7:0];
          end
          `OFS_NEXT_PTR_HIGH: begin
            local_byte_next = {5'h00, next_ptr_reg[10:8]};
          end
          `OFS_LOG_ADDR_LOW: begin
            local_byte_next = log_addr_reg[7:0];
          end
          `OFS_LOG_ADDR_HIGH: begin
            local_byte_next = {5'h00, log_addr_reg[10:8]};
          end
          `OFS_LOG_DATA: begin
            // RULE18 the log is reached only here
            src_next     = SRC_RAM;
            ram_rd_en    = 1'b1;
            // RULE4 pointer holds at the data byte
            reg_ptr_next = reg_ptr_reg;
            // RULE5 no step past the last location
            if (log_addr_reg != `LOG_ADDR_LAST) begin
              log_addr_next = log_addr_reg + 11'h001;
            end
          end
          default: begin
            // RULE12 reserved space reads zero
            local_byte_next = `RESERVED_READ;
          end
        endcase
      end
    end
    if (state_reg == ST_FETCH) begin
      state_next = ST_IDLE;
    end
  end

  // Host side registers
  always @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_reg         <= ST_IDLE;
      src_reg           <= SRC_LOCAL;
      local_byte_reg    <= 8'h00;
      reg_ptr_reg       <= `REG_PTR_RESET;
      addr_phase_reg    <= 1'b0;
      log_addr_reg      <= `LOG_ADDR_RESET;
      interval_high_reg <= 8'h00;
      ext_wr_reg        <= 1'b0;
      ext_rd_reg        <= 1'b0;
      ext_addr_reg      <= 6'h00;
      ext_wdata_reg     <= 8'h00;
    end else begin
      case (state_next)
        ST_IDLE:  state_reg <= ST_IDLE;
        ST_FETCH: state_reg <= ST_FETCH;
        default:  state_reg <= ST_IDLE;
      endcase
      src_reg           <= src_next;
      local_byte_reg    <= local_byte_next;
      reg_ptr_reg       <= reg_ptr_next;
      addr_phase_reg    <= addr_phase_next;
      log_addr_reg      <= log_addr_next;
      interval_high_reg <= interval_high_next;
      ext_wr_reg        <= ext_wr_next;
      ext_rd_reg        <= ext_rd_next;
      ext_addr_reg      <= ext_addr_next;
      ext_wdata_reg     <= ext_wdata_next;
    end
  end

  // Next-write pointer follows each completed event pair.
  // RULE7 event ends on its odd, high byte
  // RULE9 wrap leaves it on the oldest entry
  always @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      next_ptr_reg <= `NEXT_PTR_RESET;
    end else if (log_wr_en_in && log_wr_addr_in[0]) begin
      next_ptr_reg <= log_wr_addr_in + 11'h001;
    end
  end

  // Mission stop request; a new write wins over the clear.
  // RULE15 stop waits for the event store to finish
  always @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      stop_pend_reg  <= 1'b0;
      stop_pulse_reg <= 1'b0;
    end else begin
      stop_pulse_reg <= stop_pend_reg & ~event_store_busy_in;
      if (mission_write) begin
        stop_pend_reg <= 1'b1;
      end else if (!event_store_busy_in || !mission_on) begin
        stop_pend_reg <= 1'b0;
      end
    end
  end

  // Log memory, written by the logging engine, read by the host
  log_ram #(
    .ADDR_W (`LOG_ADDR_W),
    .DATA_W (8)
  ) u_log_ram (
    .clock_in    (clock_in),
    .wr_en_in    (log_wr_en_in),
    .wr_addr_in  (log_wr_addr_in),
    .wr_data_in  (log_wr_data_in),
    .rd_en_in    (ram_rd_en),
    .rd_addr_in  (log_addr_reg),
    .rd_data_out (ram_rd_data)
  );

  // Answer queue; a slow host stalls new read requests through ready
  byte_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH),
    .PTR_W (FIFO_PTR_W)
  ) u_read_fifo (
    .clock_in      (clock_in),
    .rst_b_in      (rst_b_in),
    .in_valid_in   (fifo_push),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    (push_data),
    .out_valid_out (host_rd_valid_out),
    .out_ready_in  (host_rd_ack_in),
    .out_data_out  (host_rd_data_out)
  );
endmodule // event_log_access_port

// ### event_log_access_port_assertions.sv
// Purpose: Port-level checks for the event log access port.
// Assumes: One clock domain; reset is asynchronous and active low.
// Notes:   Bound to every instance of the port.
`timescale 1ns/1ps
module event_log_access_port_checker (
  // Clock and reset
  input wire        clock_in,
  input wire        rst_b_in,
  // Host side
  input wire        host_wr_valid_in,
  input wire        host_rd_req_in,
  input wire        host_rd_ack_in,
  input wire        host_rd_ready_out,
  input wire        host_rd_valid_out,
  input wire [7:0]  host_rd_data_out,
  // Recorder side
  input wire        power_fail_threshold_in,
  input wire        mission_active_flag_in,
  input wire        mission_enable_bit_in,
  input wire        event_store_busy_in,
  input wire        log_wr_en_in,
  input wire [10:0] log_wr_addr_in,
  input wire        ext_wr_out,
  input wire        mission_stop_out,
  input wire        access_blocked_out,
  input wire [10:0] next_write_ptr_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);
  // Either flag means a mission runs
  wire mission_on = mission_active_flag_in | mission_enable_bit_in;

  property p_block_follows;
    access_blocked_out == power_fail_threshold_in;
  endproperty
  a_block_follows: assert property (p_block_follows)
    else $error("blocked flag differs from power fail");
  property p_pf_no_write;
    power_fail_threshold_in && host_wr_valid_in |=> !ext_wr_out;
  endproperty
  a_pf_no_write: assert property (p_pf_no_write)
    else $error("write passed during power fail");
  property p_mission_no_write;
    mission_on && host_wr_valid_in |=> !ext_wr_out;
  endproperty
  a_mission_no_write: assert property (p_mission_no_write)
    else $error("write passed during mission");
  property p_answer_due;
    host_rd_req_in && host_rd_ready_out |-> ##[2:3] host_rd_valid_out;
  endproperty
  a_answer_due: assert property (p_answer_due)
    else $error("read answer late");
  property p_answer_held;
    host_rd_valid_out && !host_rd_ack_in
      |=> host_rd_valid_out && $stable(host_rd_data_out);
  endproperty
  a_answer_held: assert property (p_answer_held)
    else $error("read answer dropped before ack");
  property p_stop_one;
    mission_stop_out |=> !mission_stop_out;
  endproperty
  a_stop_one: assert property (p_stop_one)
    else $error("mission stop longer than one cycle");
  property p_stop_after_store;
    mission_stop_out |-> !$past(event_store_busy_in);
  endproperty
  a_stop_after_store: assert property (p_stop_after_store)
    else $error("mission stop while event stored");
  property p_ptr_follows;
    log_wr_en_in && log_wr_addr_in[0]
      |=> next_write_ptr_out == $past(log_wr_addr_in) + 11'h001;
  endproperty
  a_ptr_follows: assert property (p_ptr_follows)
    else $error("next write pointer wrong");
endmodule // event_log_access_port_checker

bind event_log_access_port event_log_access_port_checker u_chk (.*);

// ### host_model.sv
// Purpose: Byte-level model of the serial bus master facing the port.
// Assumes: Called at a clock edge plus 1 ns.
// Notes:   Every wait is bounded; a stuck port raises hang_out.
`timescale 1ns/1ps
module host_model (
  // Clock
  input  wire       clock_in,
  // Byte strobes towards the port
  output reg        start_out,
  output reg        stop_out,
  output reg        wr_valid_out,
  output reg  [7:0] wr_data_out,
  // Read handshake
  output reg        rd_req_out,
  output reg        rd_ack_out,
  input  wire       rd_ready_in,
  input  wire       rd_valid_in,
  input  wire [7:0] rd_data_in,
  // Port never answered
  output reg        hang_out
);
  // Idle bus levels from time zero
  initial begin
    start_out = 1'b0;
    stop_out = 1'b0;
    wr_valid_out = 1'b0;
    wr_data_out = 8'h00;
    rd_req_out = 1'b0;
    rd_ack_out = 1'b0;
    hang_out = 1'b0;
  end
  task tick;
    @(posedge clock_in);
    #1;
  endtask
  task pulse_start;
    start_out = 1'b1;
    tick;
    start_out = 1'b0;
    tick;
  endtask
  task pulse_stop;
    stop_out = 1'b1;
    tick;
    stop_out = 1'b0;
    tick;
  endtask
  // Data is inverted after the strobe so stale bytes never look valid
  task send_byte(input [7:0] b);
    wr_data_out = b;
    wr_valid_out = 1'b1;
    tick;
    wr_valid_out = 1'b0;
    wr_data_out = ~b;
    tick;
  endtask
  task read_byte(output [7:0] b);
    integer n;
    n = 0;
    while (rd_ready_in !== 1'b1 && n < 50) begin
      tick;
      n = n + 1;
    end
    rd_req_out = 1'b1;
    tick;
    rd_req_out = 1'b0;
    while (rd_valid_in !== 1'b1 && n < 100) begin
      tick;
      n = n + 1;
    end
    if (n >= 50) hang_out = 1'b1;
    b = rd_data_in;
    rd_ack_out = 1'b1;
    tick;
    rd_ack_out = 1'b0;
    tick;
  endtask
endmodule // host_model

// ### test_event_log_memory_access_port.sv
// Purpose: Self-checking bench for the event log access port.
// Assumes: Outside storage answers {2'b10, address} on reads.
// Notes:   Log bytes hold address low byte xor 5ah.
`timescale 1ns/1ps
module test_event_log_memory_access_port;
  // Clock, reset and recorder side
  logic        clock_in, rst_b_in, power_fail_threshold_in;
  logic        mission_active_flag_in, mission_enable_bit_in;
  logic        event_store_busy_in, log_wr_en_in;
  logic [15:0] elapsed_interval_counter_in;
  logic [10:0] log_wr_addr_in;
  logic [7:0]  log_wr_data_in;
  // Host side and outside storage
  wire         host_start_in, host_stop_in, host_wr_valid_in, host_rd_req_in;
  wire         host_rd_ack_in, host_rd_ready_out, host_rd_valid_out, hang;
  wire  [7:0]  host_wr_data_in, host_rd_data_out, ext_wdata_out;
  wire         ext_wr_out, ext_rd_out, mission_stop_out, access_blocked_out;
  wire  [5:0]  ext_addr_out;
  wire  [10:0] next_write_ptr_out;
  wire  [7:0]  ext_rdata_in = {2'b10, ext_addr_out};
  logic [7:0]  n_ext_wr = 8'h00, n_stop = 8'h00, ext_a = 8'h00, ext_d = 8'h00;
  logic [7:0]  n_ext_rd = 8'h00;
  logic [7:0]  v;
  integer      num_errors = 0, n_compared = 0, i;

  always #4 clock_in = ~clock_in;

  event_log_access_port uut (.clock_in, .rst_b_in, .host_start_in,
    .host_stop_in, .host_wr_valid_in, .host_wr_data_in, .host_rd_req_in,
    .host_rd_ready_out, .host_rd_valid_out, .host_rd_data_out, .host_rd_ack_in,
    .power_fail_threshold_in, .mission_active_flag_in, .mission_enable_bit_in,
    .event_store_busy_in, .elapsed_interval_counter_in, .log_wr_en_in,
    .log_wr_addr_in, .log_wr_data_in, .ext_wr_out, .ext_rd_out, .ext_addr_out,
    .ext_wdata_out, .ext_rdata_in, .mission_stop_out, .access_blocked_out,
    .next_write_ptr_out);
  host_model u_host (.clock_in, .start_out(host_start_in),
    .stop_out(host_stop_in), .wr_valid_out(host_wr_valid_in),
    .wr_data_out(host_wr_data_in), .rd_req_out(host_rd_req_in),
    .rd_ack_out(host_rd_ack_in), .rd_ready_in(host_rd_ready_out),
    .rd_valid_in(host_rd_valid_out), .rd_data_in(host_rd_data_out),
    .hang_out(hang));

  // Count outside writes and mission stops as they happen
  always @(posedge clock_in) begin
    if (ext_wr_out === 1'b1) begin
      n_ext_wr <= n_ext_wr + 8'h01;
      ext_a <= {2'b00, ext_addr_out};
      ext_d <= ext_wdata_out;
    end
    if (mission_stop_out === 1'b1) n_stop <= n_stop + 8'h01;
    if (ext_rd_out === 1'b1) n_ext_rd <= n_ext_rd + 8'h01;
  end

  task tick;
    @(posedge clock_in);
    #1;
  endtask
  task stop_test;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task check8(input [7:0] got, input [7:0] exp);
    n_compared = n_compared + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  function [7:0] log_val(input [10:0] a);
    log_val = a[7:0] ^ 8'h5a;
  endfunction
  // Engine side: one log byte per cycle, strobe kept up between bytes
  task log_put(input [10:0] a);
    log_wr_en_in = 1'b1;
    log_wr_addr_in = a;
    log_wr_data_in = log_val(a);
    tick;
  endtask
  // Set the register pointer, then restart for reading
  task point(input [7:0] r);
    u_host.pulse_start;
    u_host.send_byte(r);
    u_host.pulse_start;
  endtask
  task expect_rd(input [7:0] e);
    u_host.read_byte(v);
    check8(v, e);
  endtask

  task t_log_fill;
    log_put(11'h7fc);
    log_put(11'h7fd);
    log_wr_en_in = 1'b0;
    tick;
    point(8'h3f);
    expect_rd(8'hfe);
    expect_rd(8'h07);
    u_host.pulse_stop;
    log_put(11'h7fe);
    log_put(11'h7ff);
    for (i = 0; i < 6; i = i + 1) log_put(i[10:0]);
    log_wr_en_in = 1'b0;
    tick;
    check8(next_write_ptr_out[7:0], 8'h06);
  endtask
  // address low, high, restart, read on
  task t_indirect;
    u_host.pulse_start;
    u_host.send_byte(8'h41);
    u_host.send_byte(8'h02);
    u_host.send_byte(8'h00);
    u_host.pulse_start;
    for (i = 2; i < 5; i = i + 1) expect_rd(log_val(i[10:0]));
    point(8'h41);
    expect_rd(8'h05);
    expect_rd(8'h00);
    u_host.pulse_stop;
  endtask
  task t_top_end;
    u_host.pulse_start;
    u_host.send_byte(8'h41);
    u_host.send_byte(8'hfe);
    u_host.send_byte(8'hff);
    u_host.pulse_start;
    for (i = 0; i < 4; i = i + 1)
      expect_rd(log_val(i == 0 ? 11'h7fe : 11'h7ff));
    point(8'h42);
    expect_rd(8'h07);
    u_host.pulse_stop;
  endtask
  task t_map;
    point(8'h3d);
    expect_rd(8'hef);
    elapsed_interval_counter_in = 16'h1234;
    expect_rd(8'hbe);
    point(8'h44);
    expect_rd(8'h00);
    point(8'hff);
    expect_rd(8'h00);
    point(8'h05);
    expect_rd(8'h85);
    check8(n_ext_rd, 8'h01);
    u_host.pulse_start;
    u_host.send_byte(8'h10);
    u_host.send_byte(8'ha5);
    u_host.send_byte(8'h5c);
    check8(ext_d, 8'h5c);
    check8(ext_a, 8'h11);
    u_host.pulse_start;
    u_host.send_byte(8'h3d);
    u_host.send_byte(8'h77);
    check8(n_ext_wr, 8'h02);
    u_host.pulse_stop;
  endtask
  task t_mission;
    mission_enable_bit_in = 1'b1;
    point(8'h3f);
    expect_rd(8'h00);
    point(8'h10);
    expect_rd(8'h90);
    mission_enable_bit_in = 1'b0;
    mission_active_flag_in = 1'b1;
    event_store_busy_in = 1'b1;
    u_host.pulse_start;
    u_host.send_byte(8'h10);
    u_host.send_byte(8'h33);
    repeat (4) tick;
    check8(n_stop, 8'h00);
    event_store_busy_in = 1'b0;
    repeat (4) tick;
    check8({7'h00, n_stop != 8'h00}, 8'h01);
    check8(n_ext_wr, 8'h02);
    mission_active_flag_in = 1'b0;
    u_host.pulse_stop;
  endtask
  task t_power;
    power_fail_threshold_in = 1'b1;
    tick;
    check8({7'h00, access_blocked_out}, 8'h01);
    u_host.pulse_start;
    u_host.send_byte(8'h10);
    u_host.send_byte(8'h44);
    point(8'h3d);
    expect_rd(8'h00);
    power_fail_threshold_in = 1'b0;
    point(8'h3d);
    expect_rd(8'h34);
    check8(n_ext_wr, 8'h02);
    u_host.pulse_stop;
  endtask

  // A host wait that ran out ends the run
  always @(posedge hang) begin
    num_errors = num_errors + 1;
    stop_test;
  end

  initial begin
    clock_in = 1'b0;
    rst_b_in = 1'b0;
    power_fail_threshold_in = 1'b0;
    mission_active_flag_in = 1'b0;
    mission_enable_bit_in = 1'b0;
    event_store_busy_in = 1'b0;
    elapsed_interval_counter_in = 16'hbeef;
    log_wr_en_in = 1'b0;
    log_wr_addr_in = 11'h000;
    log_wr_data_in = 8'h00;
    repeat (10) @(posedge clock_in);
    #1;
    rst_b_in = 1'b1;
    tick;
    t_log_fill;
    t_indirect;
    t_top_end;
    t_map;
    t_mission;
    t_power;
    stop_test;
  end
endmodule // test_event_log_memory_access_port
